// [logic/xop_add16.v]
// Sixteen-bit base plus unsigned byte adder, modulo 65536
`timescale 1ns/100ps
module xop_add16 #(
    parameter AW = 16
) (
    // Operands
    input  wire [AW-1:0] base,
    input  wire [7:0]    offset,
    // Result
    output wire [AW-1:0] sum
);

    // ======================================================
    // Carry from the low byte ripples through; top carry drops
    assign sum = base + {{(AW-8){1'b0}}, offset};

endmodule

// [logic/xop_core.v]
// Extended opcode fetch, decode and execute unit
//
// Summary of operation
// - Escape byte A5 prefixes every extended opcode
// - Increment unselected pointer modulo 65536, no flags
// - Increment encoding A5 A3, two bytes, three cycles
// - Select zero makes second pointer the alternate
// - Jump to PC plus two plus accumulator
// - Shift forty-bit sum left, zero in, no flags
// - Code byte at accumulator plus alternate pointer
// - Signed 16x16 product added to 40-bit sum
// - Overflow set on signed overflow, cleared only by reset or a flags write
// - Carry follows sign of accumulated result
// - Load alternate pointer, high byte first
// - External read through alternate pointer into accumulator
// - External write of accumulator through alternate pointer
// - External read three cycles near, five far
`timescale 1ns/100ps
`include "xop_defines.vh"
module xop_core #(
    parameter AW       = 16,
    parameter NEAR_TOP = 16'h1000
) (
    // Clock and reset
    input  wire          clk_sys,
    input  wire          resetn,
    // Execution control
    input  wire          run,
    input  wire          pointer_select,
    // Core register write port
    input  wire          wr_en,
    input  wire [3:0]    wr_sel,
    input  wire [7:0]    wr_data,
    // Program memory, combinational read
    output wire [AW-1:0] code_addr,
    input  wire [7:0]    code_rdata,
    // Data memory, combinational read
    output wire [AW-1:0] data_addr,
    output wire          data_rd,
    output wire          data_wr,
    output wire          data_far,
    output wire [7:0]    data_wdata,
    input  wire [7:0]    data_rdata,
    // Architectural state
    output wire [AW-1:0] pc,
    output wire [7:0]    acc,
    output wire [7:0]    b_reg,
    output wire [7:0]    acc_high_extension,
    output wire [7:0]    b_high_extension,
    output wire [AW-1:0] first_pointer,
    output wire [AW-1:0] second_pointer,
    output wire [39:0]   mac_sum,
    output wire          flag_cy,
    output wire          flag_ov,
    // Status
    output wire          busy,
    output reg           done_r,
    output reg           foreign_r
);

    // ======================================================
    // State registers
    reg  [AW-1:0] pc_r;
    reg  [7:0]    acc_r;
    reg  [7:0]    b_r;
    reg  [7:0]    ax_r;
    reg  [7:0]    bx_r;
    reg  [AW-1:0] fp_r;
    reg  [AW-1:0] sp_r;
    reg  [39:0]   sum_r;
    reg           cy_r;
    reg           ov_r;
    reg           busy_r;
    reg  [3:0]    cnt_r;
    reg  [7:0]    op_r;
    reg  [7:0]    imm_hi_r;

    // ======================================================
    // Decode helpers
    wire [7:0]    op_cur;
    wire [AW-1:0] alt_ptr;
    wire [AW-1:0] alt_plus_acc;
    wire [AW-1:0] alt_plus_one;
    wire [AW-1:0] fetch_addr;
    wire [AW-1:0] pc_plus_two;
    wire [AW-1:0] jump_target;
    wire [39:0]   mac_out;
    wire          mac_ovf;
    wire          mac_neg;
    wire          is_xrd;
    wire          is_xwr;
    wire          in_data;
    reg  [3:0]    last_cnt;
    wire          last;

    // The opcode byte is live in cycle 1 and held afterwards
    assign op_cur = (cnt_r == `XOP_CYC_OPCODE) ? code_rdata : op_r;

    // Unselected pointer: select low picks the second one
    assign alt_ptr = pointer_select ? fp_r : sp_r;

    // Instruction bytes come from consecutive addresses
    assign fetch_addr  = pc_r + {{(AW-4){1'b0}}, cnt_r};
    assign pc_plus_two = pc_r + {{(AW-2){1'b0}}, 2'b10};

    // ======================================================
    // Shared adders
    xop_add16 #(.AW(AW)) u_alt_acc (
        .base   (alt_ptr),
        .offset (acc_r),
        .sum    (alt_plus_acc)
    );

    xop_add16 #(.AW(AW)) u_alt_inc (
        .base   (alt_ptr),
        .offset (8'h01),
        .sum    (alt_plus_one)
    );

    xop_add16 #(.AW(AW)) u_jump (
        .base   (pc_plus_two),
        .offset (acc_r),
        .sum    (jump_target)
    );

    // ======================================================
    // Multiply-accumulate datapath
    xop_mac u_mac (
        .a_lo     (acc_r),
        .a_hi     (ax_r),
        .b_lo     (b_r),
        .b_hi     (bx_r),
        .sum_in   (sum_r),
        .sum_out  (mac_out),
        .overflow (mac_ovf),
        .negative (mac_neg)
    );

    // ======================================================
    // Data space access through the alternate pointer
    assign is_xrd   = busy_r && (op_r == `XOP_OP_XRD_ALT);
    assign is_xwr   = busy_r && (op_r == `XOP_OP_XWR_ALT);
    assign in_data  = cnt_r >= `XOP_CYC_DATA;
    assign data_far = alt_ptr >= NEAR_TOP;
    assign data_addr  = alt_ptr;
    assign data_wdata = acc_r;
    // Read is held from its first data cycle until commit
    assign data_rd  = is_xrd && in_data;
    // Write is a single pulse in the commit cycle
    assign data_wr  = is_xwr && last;

    // Code lookup borrows the fetch port in its data cycle
    assign code_addr = (busy_r && op_r == `XOP_OP_MOVC_ALT && in_data) ?
                       alt_plus_acc : fetch_addr;

    // ======================================================
    // Completion cycle of the instruction in flight
    always @* begin
        case (op_cur)
            `XOP_OP_INC_ALT:  last_cnt = `XOP_LAST_INC;
            `XOP_OP_JMP_PC:   last_cnt = `XOP_LAST_JMP;
            `XOP_OP_LSL_SUM:  last_cnt = `XOP_LAST_LSL;
            `XOP_OP_MAC:      last_cnt = `XOP_LAST_MAC;
            `XOP_OP_MOVC_ALT: last_cnt = `XOP_LAST_MOVC;
            `XOP_OP_LOAD_ALT: last_cnt = `XOP_LAST_LOAD;
            `XOP_OP_XRD_ALT,
            `XOP_OP_XWR_ALT:  last_cnt = data_far ? `XOP_LAST_XFAR :
                                                    `XOP_LAST_XNEAR;
            default:          last_cnt = `XOP_LAST_OTHER;
        endcase
    end

    assign last = busy_r && (cnt_r == last_cnt);

    // ======================================================
    // Sequencer: escape detect, operand capture, commit.
    // Nothing architectural moves before the last cycle, so a
    // stalled or partial fetch never leaves half an update.
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy_r    <= 1'b0;
            cnt_r     <= `XOP_RST_CNT;
            op_r      <= `XOP_RST_BYTE;
            imm_hi_r  <= `XOP_RST_BYTE;
            done_r    <= 1'b0;
            foreign_r <= 1'b0;
        end else begin
            done_r    <= 1'b0;
            foreign_r <= 1'b0;
            if (!busy_r) begin
                if (run) begin
                    if (code_rdata == `XOP_ESC) begin
                        busy_r <= 1'b1;
                        cnt_r  <= `XOP_CYC_OPCODE;
                    end else begin
                        foreign_r <= 1'b1;
                    end
                end
            end else if (last) begin
                busy_r <= 1'b0;
                cnt_r  <= `XOP_RST_CNT;
                done_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == `XOP_CYC_OPCODE) begin
                    op_r <= code_rdata;
                end
                if (cnt_r == `XOP_CYC_IMM_HI) begin
                    imm_hi_r <= code_rdata;
                end
            end
        end
    end

    // ======================================================
    // Program counter: plain opcodes skip one byte, extended ones
    // other than the jump move by their byte length at commit only
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pc_r <= `XOP_RST_WORD;
        end else if (!busy_r && run && code_rdata != `XOP_ESC) begin
            pc_r <= pc_r + {{(AW-1){1'b0}}, 1'b1};
        end else if (last) begin
            if (op_cur == `XOP_OP_JMP_PC) begin
                pc_r <= jump_target;
            end else if (op_cur == `XOP_OP_LOAD_ALT) begin
                pc_r <= fetch_addr + {{(AW-1){1'b0}}, 1'b1};
            end else begin
                pc_r <= pc_plus_two;
            end
        end
    end

    // ======================================================
    // Accumulator and operand registers; the core may write them
    // only while no extended instruction is in flight
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            acc_r <= `XOP_RST_BYTE;
            b_r   <= `XOP_RST_BYTE;
            ax_r  <= `XOP_RST_BYTE;
            bx_r  <= `XOP_RST_BYTE;
        end else if (last) begin
            // Operand registers are never written by the multiply
            if (op_cur == `XOP_OP_MOVC_ALT) begin
                acc_r <= code_rdata;
            end else if (op_cur == `XOP_OP_XRD_ALT) begin
                acc_r <= data_rdata;
            end
        end else if (!busy_r && wr_en) begin
            case (wr_sel)
                `XOP_SEL_ACC: acc_r <= wr_data;
                `XOP_SEL_B:   b_r   <= wr_data;
                `XOP_SEL_AX:  ax_r  <= wr_data;
                `XOP_SEL_BX:  bx_r  <= wr_data;
                default:      acc_r <= acc_r;
            endcase
        end
    end

    // ======================================================
    // Data pointers; instructions touch only the unselected one, the write port either
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fp_r <= `XOP_RST_WORD;
            sp_r <= `XOP_RST_WORD;
        end else if (last) begin
            if (op_cur == `XOP_OP_INC_ALT) begin
                if (pointer_select) begin
                    fp_r <= alt_plus_one;
                end else begin
                    sp_r <= alt_plus_one;
                end
            end else if (op_cur == `XOP_OP_LOAD_ALT) begin
                if (pointer_select) begin
                    fp_r <= {imm_hi_r, code_rdata};
                end else begin
                    sp_r <= {imm_hi_r, code_rdata};
                end
            end
        end else if (!busy_r && wr_en) begin
            case (wr_sel)
                `XOP_SEL_FP_LO: fp_r[7:0]    <= wr_data;
                `XOP_SEL_FP_HI: fp_r[AW-1:8] <= wr_data;
                `XOP_SEL_SP_LO: sp_r[7:0]    <= wr_data;
                `XOP_SEL_SP_HI: sp_r[AW-1:8] <= wr_data;
                default:        fp_r         <= fp_r;
            endcase
        end
    end

    // ======================================================
    // Running sum and flags; overflow is sticky across products
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sum_r <= `XOP_RST_SUM;
            cy_r  <= 1'b0;
            ov_r  <= 1'b0;
        end else if (last) begin
            if (op_cur == `XOP_OP_MAC) begin
                sum_r <= mac_out;
                cy_r  <= mac_neg;
                if (mac_ovf) begin
                    ov_r <= 1'b1;
                end
            end else if (op_cur == `XOP_OP_LSL_SUM) begin
                sum_r <= {sum_r[38:0], 1'b0};
            end
        end else if (!busy_r && wr_en) begin
            if (wr_sel == `XOP_SEL_FLAGS) begin
                ov_r <= wr_data[1];
                cy_r <= wr_data[0];
            end else if (wr_sel == `XOP_SEL_SUM_CLR) begin
                sum_r <= `XOP_RST_SUM;
            end
        end
    end

    // ======================================================
    // State outputs straight from flops
    assign busy               = busy_r;
    assign pc                 = pc_r;
    assign acc                = acc_r;
    assign b_reg              = b_r;
    assign acc_high_extension = ax_r;
    assign b_high_extension   = bx_r;
    assign first_pointer      = fp_r;
    assign second_pointer     = sp_r;
    assign mac_sum            = sum_r;
    assign flag_cy            = cy_r;
    assign flag_ov            = ov_r;

endmodule

// [logic/xop_defines.vh]
// Constants for the extended opcode execution unit
`ifndef XOP_DEFINES_VH
`define XOP_DEFINES_VH

// ==========================================================
// Escape prefix and second-byte opcodes
`define XOP_ESC           8'hA5
`define XOP_OP_INC_ALT    8'hA3
`define XOP_OP_JMP_PC     8'h73
`define XOP_OP_LSL_SUM    8'h23
`define XOP_OP_MAC        8'hA4
`define XOP_OP_MOVC_ALT   8'h93
`define XOP_OP_LOAD_ALT   8'h90
`define XOP_OP_XRD_ALT    8'hE0
`define XOP_OP_XWR_ALT    8'hF0

// ==========================================================
// Last cycle index of each instruction (cycle 0 = escape byte)
`define XOP_LAST_INC      4'h2
`define XOP_LAST_JMP      4'h2
`define XOP_LAST_LSL      4'h1
`define XOP_LAST_MAC      4'h8
`define XOP_LAST_MOVC     4'h2
`define XOP_LAST_LOAD     4'h3
`define XOP_LAST_XNEAR    4'h2
`define XOP_LAST_XFAR     4'h4
`define XOP_LAST_OTHER    4'h1

// ==========================================================
// Byte positions inside an instruction
`define XOP_CYC_OPCODE    4'h1
`define XOP_CYC_IMM_HI    4'h2
`define XOP_CYC_DATA      4'h2

// ==========================================================
// Core write port selectors
`define XOP_SEL_ACC       4'h0
`define XOP_SEL_B         4'h1
`define XOP_SEL_AX        4'h2
`define XOP_SEL_BX        4'h3
`define XOP_SEL_FP_LO     4'h4
`define XOP_SEL_FP_HI     4'h5
`define XOP_SEL_SP_LO     4'h6
`define XOP_SEL_SP_HI     4'h7
`define XOP_SEL_FLAGS     4'h8
`define XOP_SEL_SUM_CLR   4'h9

// ==========================================================
// Reset values
`define XOP_RST_BYTE      8'h00
`define XOP_RST_WORD      16'h0000
`define XOP_RST_SUM       40'h00_0000_0000
`define XOP_RST_CNT       4'h0

`endif

// [logic/xop_mac.v]
// Signed 16x16 multiply added to a 40-bit running sum, with flags
`timescale 1ns/100ps
module xop_mac (
    // Operands
    input  wire [7:0]  a_lo,
    input  wire [7:0]  a_hi,
    input  wire [7:0]  b_lo,
    input  wire [7:0]  b_hi,
    input  wire [39:0] sum_in,
    // Results
    output wire [39:0] sum_out,
    output wire        overflow,
    output wire        negative
);

    wire signed [15:0] op_a;
    wire signed [15:0] op_b;
    wire signed [31:0] prod;
    wire        [39:0] prod_ext;

    // ======================================================
    // Product is sign extended to the sum width before the add
    assign op_a     = {a_hi, a_lo};
    assign op_b     = {b_hi, b_lo};
    assign prod     = op_a * op_b;
    assign prod_ext = {{8{prod[31]}}, prod};
    assign sum_out  = sum_in + prod_ext;

    // Overflow: like-signed addends giving a result of other sign
    assign overflow = (sum_in[39] == prod_ext[39]) && (sum_out[39] != sum_in[39]);
    assign negative = sum_out[39];

endmodule

// [verif/xop_core_assertions.sv]
// Concurrent checks on the extended opcode unit ports
`timescale 1ns/100ps
`include "xop_defines.vh"
module xop_core_chk (
    // Clock and reset
    input wire        clk_sys,
    input wire        resetn,
    // Control
    input wire        run,
    input wire        pointer_select,
    input wire        wr_en,
    // Memories
    input wire [7:0]  code_rdata,
    input wire [15:0] data_addr,
    input wire        data_rd,
    input wire        data_far,
    input wire [7:0]  data_rdata,
    // State and status
    input wire [15:0] pc,
    input wire [7:0]  acc,
    input wire [15:0] first_pointer,
    input wire [15:0] second_pointer,
    input wire [39:0] mac_sum,
    input wire        flag_cy,
    input wire        flag_ov,
    input wire        busy,
    input wire        done_r,
    input wire        foreign_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ========
    // Sequences
    sequence s_start;
        run && !busy && code_rdata == `XOP_ESC;
    endsequence
    sequence s_op(op);
        s_start ##1 code_rdata == op;
    endsequence

    // ========
    // Properties
    property p_esc;
        run && !busy && code_rdata != `XOP_ESC |=> foreign_r && !busy;
    endproperty
    a_esc: assert property (p_esc) else $error("plain byte not skipped");
    property p_inc;
        s_op(`XOP_OP_INC_ALT) |=> busy ##1 (done_r && !busy);
    endproperty
    a_inc: assert property (p_inc) else $error("increment timing wrong");
    property p_alt;
        data_addr == (pointer_select ? first_pointer : second_pointer);
    endproperty
    a_alt: assert property (p_alt) else $error("wrong alternate pointer");
    property p_jmp;
        s_op(`XOP_OP_JMP_PC) |=> ##1 (pc == $past(pc, 3) + 16'h0002 + acc && $stable(acc));
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump target wrong");
    property p_lsl;
        s_op(`XOP_OP_LSL_SUM) |=> mac_sum == ($past(mac_sum) << 1) && $stable(flag_cy);
    endproperty
    a_lsl: assert property (p_lsl) else $error("sum shift wrong");
    property p_cy;
        s_op(`XOP_OP_MAC) |=> ##7 (done_r && flag_cy == mac_sum[39] && acc == $past(acc, 8));
    endproperty
    a_cy: assert property (p_cy) else $error("carry not sign of sum");
    property p_ov;
        $fell(flag_ov) |-> $past(wr_en);
    endproperty
    a_ov: assert property (p_ov) else $error("overflow flag cleared");
    property p_far;
        s_op(`XOP_OP_XRD_ALT) ##1 data_far |-> data_rd [*3] ##1
            (done_r && acc == $past(data_rdata));
    endproperty
    a_far: assert property (p_far) else $error("far read timing wrong");
    // Accumulator, sum and pointers hold between the first and last cycle of an instruction
    property p_atom;
        busy && $past(busy) |-> $stable(acc) && $stable(mac_sum) && $stable(first_pointer)
            && $stable(second_pointer);
    endproperty
    a_atom: assert property (p_atom) else $error("state changed mid instruction");
endmodule

bind xop_core xop_core_chk u_xop_core_chk (
    .clk_sys(clk_sys), .resetn(resetn), .run(run), .pointer_select(pointer_select),
    .wr_en(wr_en), .code_rdata(code_rdata), .data_addr(data_addr), .data_rd(data_rd),
    .data_far(data_far), .data_rdata(data_rdata), .pc(pc), .acc(acc),
    .first_pointer(first_pointer), .second_pointer(second_pointer), .mac_sum(mac_sum),
    .flag_cy(flag_cy), .flag_ov(flag_ov), .busy(busy), .done_r(done_r),
    .foreign_r(foreign_r)
);

// [verif/xop_core_tb.sv]
// Self-checking bench for the extended opcode execution unit
`timescale 1ns/100ps
`include "xop_defines.vh"
module xop_core_tb;
    reg         clk_sys, resetn, run, pointer_select, wr_en;
    reg  [3:0]  wr_sel;
    reg  [7:0]  wr_data;
    wire [15:0] code_addr, data_addr, pc, first_pointer, second_pointer;
    wire [7:0]  code_rdata, data_wdata, data_rdata, acc, b_reg, hx_a, hx_b;
    wire [39:0] mac_sum;
    wire        data_rd, data_wr, data_far, flag_cy, flag_ov, busy, done_r, foreign_r;
    integer     error_cnt, comparisons, n;

    xop_core u_xop_core (
        .clk_sys(clk_sys), .resetn(resetn), .run(run), .pointer_select(pointer_select),
        .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .code_addr(code_addr),
        .code_rdata(code_rdata), .data_addr(data_addr), .data_rd(data_rd),
        .data_wr(data_wr), .data_far(data_far), .data_wdata(data_wdata),
        .data_rdata(data_rdata), .pc(pc), .acc(acc), .b_reg(b_reg),
        .acc_high_extension(hx_a), .b_high_extension(hx_b), .first_pointer(first_pointer),
        .second_pointer(second_pointer), .mac_sum(mac_sum), .flag_cy(flag_cy),
        .flag_ov(flag_ov), .busy(busy), .done_r(done_r), .foreign_r(foreign_r)
    );
    xop_mem_model u_xop_mem_model (
        .clk_sys(clk_sys), .code_addr(code_addr), .code_rdata(code_rdata),
        .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
        .data_wdata(data_wdata), .data_rdata(data_rdata)
    );

    // ========
    // Clock, 125 MHz
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ========
    // Shared tasks
    task print_verdict;
        begin
            if (error_cnt == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input string what, input [39:0] exp, input [39:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // Core write; a spare edge keeps the strobe from being raised twice in one step
    task wr(input [3:0] s, input [7:0] d);
        begin
            wr_en = 1'b1;
            wr_sel = s;
            wr_data = d;
            @(posedge clk_sys);
            #1 wr_en = 1'b0;
            @(posedge clk_sys);
            #1;
        end
    endtask
    // Place four bytes at pc, start one instruction, count its cycles into n
    task exec(input [7:0] b0, input [7:0] op, input [15:0] imm);
        begin
            u_xop_mem_model.cmem[pc] = b0;
            u_xop_mem_model.cmem[16'(pc + 16'h0001)] = op;
            u_xop_mem_model.cmem[16'(pc + 16'h0002)] = imm[15:8];
            u_xop_mem_model.cmem[16'(pc + 16'h0003)] = imm[7:0];
            run = 1'b1;
            @(posedge clk_sys);
            #1 run = 1'b0;
            n = 1;
            while (done_r !== 1'b1 && foreign_r !== 1'b1 && n < 20) begin
                @(posedge clk_sys);
                #1 n = n + 1;
            end
            if (n >= 20) begin
                error_cnt = error_cnt + 1;
                print_verdict;
            end
            @(posedge clk_sys);
            #1;
        end
    endtask

    // ========
    // Scenarios
    task t_inc;
        reg [15:0] p;
        begin
            wr(`XOP_SEL_FLAGS, 8'h03);
            wr(`XOP_SEL_SP_HI, 8'h12);
            wr(`XOP_SEL_SP_LO, 8'hFE);
            wr(`XOP_SEL_FP_LO, 8'hFF);
            wr(`XOP_SEL_FP_HI, 8'hFF);
            repeat (3) exec(`XOP_ESC, `XOP_OP_INC_ALT, 16'h0000);
            chk("inc cycles", 40'h3, n);
            chk("second", 40'h1301, second_pointer);
            chk("first", 40'hFFFF, first_pointer);
            pointer_select = 1'b1;
            // Two-byte instruction: the pc moves by two, not by its cycle count
            p = 16'(pc + 16'h0002);
            exec(`XOP_ESC, `XOP_OP_INC_ALT, 16'h0000);
            chk("inc pc", p, pc);
            chk("first", 40'h0000, first_pointer);
            chk("second", 40'h1301, second_pointer);
            chk("flags", 40'h3, {flag_ov, flag_cy});
        end
    endtask
    task t_jmp;
        reg [15:0] p;
        begin
            wr(`XOP_SEL_ACC, 8'hF0);
            p = 16'(pc + 16'h00F2);
            exec(`XOP_ESC, `XOP_OP_JMP_PC, 16'h0000);
            chk("jump pc", p, pc);
            chk("acc", 40'hF0, acc);
            chk("flags", 40'h3, {flag_ov, flag_cy});
        end
    endtask
    task t_mac;
        begin
            wr(`XOP_SEL_SUM_CLR, 8'h00);
            wr(`XOP_SEL_FLAGS, 8'h00);
            wr(`XOP_SEL_AX, 8'h80);
            wr(`XOP_SEL_ACC, 8'h00);
            wr(`XOP_SEL_BX, 8'h80);
            wr(`XOP_SEL_B, 8'h00);
            exec(`XOP_ESC, `XOP_OP_MAC, 16'h0000);
            chk("sum", 40'h0040000000, mac_sum);
            chk("operands", 40'h80008000, {hx_a, acc, hx_b, b_reg});
            repeat (9) exec(`XOP_ESC, `XOP_OP_LSL_SUM, 16'h0000);
            chk("shifted", 40'h8000000000, mac_sum);
            chk("flags", 40'h0, {flag_ov, flag_cy});
            // Negative sum minus a large product wraps positive
            wr(`XOP_SEL_BX, 8'h7F);
            wr(`XOP_SEL_B, 8'hFF);
            exec(`XOP_ESC, `XOP_OP_MAC, 16'h0000);
            chk("sum", 40'h7FC0008000, mac_sum);
            chk("flags", 40'h2, {flag_ov, flag_cy});
            exec(`XOP_ESC, `XOP_OP_MAC, 16'h0000);
            chk("sum", 40'h7F80010000, mac_sum);
            chk("flags", 40'h2, {flag_ov, flag_cy});
            wr(`XOP_SEL_SUM_CLR, 8'h00);
            wr(`XOP_SEL_FLAGS, 8'h00);
            exec(`XOP_ESC, `XOP_OP_MAC, 16'h0000);
            chk("sum", 40'hFFC0008000, mac_sum);
            chk("flags", 40'h1, {flag_ov, flag_cy});
        end
    endtask
    task t_mem;
        reg [15:0] p;
        begin
            pointer_select = 1'b0;
            wr(`XOP_SEL_SP_HI, 8'h20);
            wr(`XOP_SEL_SP_LO, 8'hF0);
            wr(`XOP_SEL_ACC, 8'h20);
            u_xop_mem_model.cmem[16'h2110] = 8'h5A;
            exec(`XOP_ESC, `XOP_OP_MOVC_ALT, 16'h0000);
            chk("lookup", 40'h5A, acc);
            chk("second", 40'h20F0, second_pointer);
            pointer_select = 1'b1;
            exec(`XOP_ESC, `XOP_OP_LOAD_ALT, 16'h5678);
            chk("first", 40'h5678, first_pointer);
            chk("second", 40'h20F0, second_pointer);
            u_xop_mem_model.dmem[16'h5678] = 8'h96;
            exec(`XOP_ESC, `XOP_OP_XRD_ALT, 16'h0000);
            chk("read", 40'h96, acc);
            pointer_select = 1'b0;
            exec(`XOP_ESC, `XOP_OP_LOAD_ALT, 16'h0123);
            u_xop_mem_model.dmem[16'h0123] = 8'h3C;
            exec(`XOP_ESC, `XOP_OP_XRD_ALT, 16'h0000);
            chk("read", 40'h3C, acc);
            chk("near cycles", 40'h3, n);
            exec(`XOP_ESC, `XOP_OP_LOAD_ALT, 16'h4567);
            u_xop_mem_model.dmem[16'h4567] = 8'hC3;
            // Extra wait states of a far read must not move the pc further
            p = 16'(pc + 16'h0002);
            exec(`XOP_ESC, `XOP_OP_XRD_ALT, 16'h0000);
            chk("read", 40'hC3, acc);
            chk("far cycles", 40'h5, n);
            chk("far read pc", p, pc);
            wr(`XOP_SEL_ACC, 8'h77);
            exec(`XOP_ESC, `XOP_OP_XWR_ALT, 16'h0000);
            chk("written", 40'h77, u_xop_mem_model.dmem[16'h4567]);
            p = 16'(pc + 16'h0001);
            exec(8'h00, 8'h00, 16'h0000);
            chk("plain pc", p, pc);
        end
    endtask

    // ========
    // Main sequence
    initial begin
        resetn = 1'b0;
        run = 1'b0;
        pointer_select = 1'b0;
        wr_en = 1'b0;
        wr_sel = 4'h0;
        wr_data = 8'h00;
        error_cnt = 0;
        comparisons = 0;
        n = 0;
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        t_inc;
        t_jmp;
        t_mac;
        t_mem;
        print_verdict;
    end
endmodule

// [verif/xop_mem_model.sv]
// Program and data memory partner for the extended opcode unit
`timescale 1ns/100ps
module xop_mem_model (
    // Clock
    input  wire        clk_sys,
    // Program memory
    input  wire [15:0] code_addr,
    output wire [7:0]  code_rdata,
    // Data memory
    input  wire [15:0] data_addr,
    input  wire        data_rd,
    input  wire        data_wr,
    input  wire [7:0]  data_wdata,
    output wire [7:0]  data_rdata
);
    reg [7:0] cmem [0:65535];
    reg [7:0] dmem [0:65535];
    reg [7:0] last_r;

    initial last_r = 8'h00;
    // Code byte follows the address in the same cycle
    assign code_rdata = cmem[code_addr];
    // Idle bus shows the inverse of the last byte, so stale data never matches
    assign data_rdata = data_rd ? dmem[data_addr] : ~last_r;
    // Store on the write pulse, remember the last byte read
    always @(posedge clk_sys) begin
        if (data_wr) begin
            dmem[data_addr] <= data_wdata;
        end
        if (data_rd) begin
            last_r <= dmem[data_addr];
        end
    end
endmodule
